// [bench/ccpsg_far_model.sv]
`timescale 1ns/10ps
module ccpsg_far_model (
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  input  wire logic run_i,
  output logic      tb_reset_o,
  output logic      period_start_o,
  output logic      pwm_o
);
  logic [3:0] cnt_reg;
  // a stopped time base never rolls over, so held updates stay pending
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_reg <= 4'h0;
    end else if (run_i) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  assign tb_reset_o     = run_i && (cnt_reg == 4'hf);
  assign period_start_o = tb_reset_o;
  assign pwm_o          = !cnt_reg[3];
endmodule

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
  import ccpsg_pkg::*;
  logic        mclk_i, resetn_i, wr_i, rd_i, run, tbr, pst, pwm, hit;
  logic [11:0] addr_i;
  logic [15:0] wdata_i, rdata_o, d;
  logic [7:0]  shd, cap;
  logic [5:0]  pin_out_o, pin_oe_n_o;
  logic        cap_evt_o, aux_o, irq_o;
  logic        msig, tmode;
  int          num_errors, checked, zeros;

  ccpsg_ctrl i_ccpsg_ctrl (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .shd_src_i(shd), .cap_src_i(cap),
    .tb_reset_i(tbr), .period_start_i(pst), .pwm_i(pwm),
    .cmp_evt_i(1'b0), .mode_sig_i(msig), .timer_mode_i(tmode),
    .ss_ace_i(2'b10), .ss_bdf_i(2'b10), .pin_out_o(pin_out_o),
    .pin_oe_n_o(pin_oe_n_o), .cap_evt_o(cap_evt_o), .aux_o(aux_o),
    .irq_o(irq_o));
  ccpsg_far_model i_ccpsg_far_model (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .run_i(run), .tb_reset_o(tbr),
    .period_start_o(pst), .pwm_o(pwm));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  // data only stands in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [15:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(posedge mclk_i);
    v = rdata_o;
  endtask

  task automatic watch(input bit use_aux, output logic h);
    h = 1'b0;
    repeat (20) begin
      @(posedge mclk_i);
      if ((use_aux ? aux_o : cap_evt_o) === 1'b1) h = 1'b1;
    end
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    resetn_i = 1'b0; wr_i = 1'b0; rd_i = 1'b0; run = 1'b0;
    addr_i = 12'h000; wdata_i = 16'h0000; shd = 8'h00; cap = 8'h00;
    num_errors = 0; checked = 0; msig = 1'b0; tmode = 1'b0; zeros = 0;
    wt(2);
    resetn_i <= 1'b1;
    rd(12'h294, d); chk(d, CCPSG_SGC_RST);
    rd(12'h296, d); chk(d, CCPSG_OSC_RST);
    rd(12'h2fe, d); chk(d, 16'h0000);
    wr(12'h298, 16'hffff); rd(12'h298, d); chk(d, 16'h003f);
    wr(12'h296, 16'h3f00); wt(3); chk(pin_oe_n_o, 16'h0000);
    wr(12'h296, 16'h8000); wt(4); chk(pin_oe_n_o, 16'h0000);
    run <= 1'b1; wt(20); chk(pin_oe_n_o, 16'h003f);
    wr(12'h296, 16'h3f00); wt(20); chk(pin_out_o, 16'h0000);
    wr(12'h298, 16'h0000); wt(12);
    chk(pin_out_o ^ {pin_out_o[4:0], pin_out_o[5]}, 16'h003f);
    wr(12'h298, 16'h0003); wt(10);
    repeat (32) begin
      @(posedge mclk_i);
      if (pin_out_o === 6'h00) zeros++;
    end
    chk(16'(zeros), 16'h000c);
    run <= 1'b0;
    wr(12'h2a2, 16'h0001);
    wr(12'h294, 16'h4040); shd <= 8'h40; wt(6);
    rd(12'h29c, d); chk(d & 16'h0010, 16'h0000);
    run <= 1'b1; wt(20);
    rd(12'h29c, d); chk(d & 16'h0010, 16'h0010);
    chk(irq_o, 16'h0001);
    chk(pin_out_o, 16'h0000);
    chk(pin_oe_n_o, 16'h0000);
    wr(12'h294, 16'h8040); shd <= 8'h00; wt(40);
    rd(12'h29c, d); chk(d & 16'h0010, 16'h0000);
    wr(12'h294, 16'h0040); shd <= 8'h40; wt(6); shd <= 8'h00; wt(40);
    rd(12'h29c, d); chk(d & 16'h0010, 16'h0010);
    wr(12'h29c, 16'h0010); wt(2);
    rd(12'h29c, d); chk(d & 16'h0010, 16'h0000);
    wr(12'h2a0, 16'h0007); wt(2); chk(irq_o, 16'h0000);
    wr(12'h294, 16'h1000); wt(3);
    rd(12'h29c, d); chk(d & 16'h0410, 16'h0010);
    for (int i = 0; i < 8; i++) begin
      wr(12'h296, 16'(i)); cap <= 8'(1 << i);
      watch(1'b0, hit); chk(hit, 16'h0001);
      cap <= 8'h00; wt(3);
    end
    wr(12'h296, 16'h0000); wr(12'h294, 16'h0000); wt(4); cap <= 8'h01;
    watch(1'b0, hit); chk(hit, 16'h0000);
    cap <= 8'h00;
    wr(12'h296, 16'h0040); wr(12'h29c, 16'h0400);
    wr(12'h294, 16'h1000); wt(5);
    rd(12'h29c, d); chk(d & 16'h0004, 16'h0000);
    wr(12'h296, 16'h0080); wr(12'h29c, 16'h0400);
    wr(12'h294, 16'h0000); wt(5);
    rd(12'h29c, d); chk(d & 16'h0004, 16'h0004);
    wr(12'h296, 16'h0008); watch(1'b1, hit); chk(hit, 16'h0001);
    wr(12'h294, 16'h1000); wr(12'h296, 16'h0018); cap <= 8'h01;
    watch(1'b1, hit); chk(hit, 16'h0001);
    cap <= 8'h00; tmode <= 1'b1; wt(3); cap <= 8'h01;
    watch(1'b1, hit); chk(hit, 16'h0000);
    tmode <= 1'b0; cap <= 8'h00; wr(12'h296, 16'h0010); msig <= 1'b1;
    watch(1'b1, hit); chk(hit, 16'h0001);
    msig <= 1'b0;
    wr(12'h296, 16'h0000); wt(3);
    watch(1'b1, hit); chk(hit, 16'h0000);
    print_verdict;
  end

  initial begin
    #20000;
    num_errors++;
    print_verdict;
  end
endmodule

// [rtl/ccpsg_ctrl.sv]
`timescale 1ns/10ps
module ccpsg_ctrl
  import ccpsg_pkg::*;
#(
  parameter bit MULTI_OUTPUT = 1'b1
) (
  input  wire logic        mclk_i,
  input  wire logic        resetn_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic [7:0]  shd_src_i,
  input  wire logic [7:0]  cap_src_i,
  input  wire logic        tb_reset_i,
  input  wire logic        period_start_i,
  input  wire logic        pwm_i,
  input  wire logic        cmp_evt_i,
  input  wire logic        mode_sig_i,
  input  wire logic        timer_mode_i,
  input  wire logic [1:0]  ss_ace_i,
  input  wire logic [1:0]  ss_bdf_i,
  output logic      [5:0]  pin_out_o,
  output logic      [5:0]  pin_oe_n_o,
  output logic             cap_evt_o,
  output logic             aux_o,
  output logic             irq_o
);

  localparam logic [15:0] OSC_WMASK = MULTI_OUTPUT ? CCPSG_OSC_MASK
                                      : (CCPSG_OSC_MASK & ~CCPSG_OSC_UPPER);

  ccpsg_state_t r;
  ccpsg_state_t n;
  logic         req;
  logic         rise;
  logic         fall;
  logic         capin;
  logic [7:0]   capv;
  logic         wr_sgc;
  logic         wr_osc;
  logic         wr_dtc;
  logic         wr_stat;
  logic         wr_ist;
  logic         wr_imsk;
  logic         shd_set;
  logic         shd_clr;
  logic         live;
  logic         wave_a;
  logic         wave_b;
  logic         wave;
  logic [1:0]   ss;
  logic [2:0]   ev;
  logic [15:0]  stat;
  ccpsg_gmode_t gmode;

  always_comb begin
    n = r;
    // pins and sibling outputs are asynchronous to mclk_i
    n.sync1 = {cap_src_i, shd_src_i};
    n.sync2 = r.sync1;

    wr_sgc  = wr_i && (addr_i == CCPSG_SGC_OFS);
    wr_osc  = wr_i && (addr_i == CCPSG_OSC_OFS);
    wr_dtc  = wr_i && (addr_i == CCPSG_DTC_OFS);
    wr_stat = wr_i && (addr_i == CCPSG_STAT_OFS);
    wr_ist  = wr_i && (addr_i == CCPSG_IST_OFS);
    wr_imsk = wr_i && (addr_i == CCPSG_IMSK_OFS);

    if (wr_sgc) begin
      n.sgc = wdata_i & CCPSG_SGC_MASK;
    end
    if (wr_osc) begin
      n.osc = wdata_i & OSC_WMASK;
    end
    if (wr_dtc) begin
      n.dtc = wdata_i & CCPSG_DTC_MASK;
    end
    if (wr_imsk) begin
      n.imsk = wdata_i[2:0];
    end

    // bit i of the enables pairs with bit i of the synced source vector
    req = (|(r.sync2[7:0] & r.sgc[7:0]))
          | r.sgc[CCPSG_SOFTWARE_SHUTDOWN_GATE_BIT];
    rise = req & ~r.req_d;
    fall = ~req & r.req_d;
    n.req_d = req;

    // enable changes wait for the rollover when sync is on
    if (!n.osc[CCPSG_PSYNC_BIT] || tb_reset_i) begin
      n.pen_act = n.osc[13:8];
    end

    // set wins over both clears
    shd_set = req && (!r.sgc[CCPSG_GMODE_BIT] || tb_reset_i);
    shd_clr = (r.sgc[CCPSG_RSEN_BIT] && !req && period_start_i)
              || (wr_stat && wdata_i[CCPSG_SHD_BIT]);
    if (shd_clr) begin
      n.shd = 1'b0;
    end
    if (shd_set) begin
      n.shd = 1'b1;
    end

    if (wr_stat && wdata_i[CCPSG_ARM_BIT]) begin
      n.arm = 1'b1;
    end
    if (wr_stat && wdata_i[CCPSG_CDIS_BIT]) begin
      n.cdis = 1'b0;
    end
    gmode = ccpsg_gmode_t'(r.osc[7:6]);
    case (gmode)
      CCPSG_CG_LEVEL: begin
        n.cdis = ~req;
      end
      CCPSG_CG_FALL: begin
        if (r.arm && fall) begin
          n.cdis = 1'b1;
          n.arm  = 1'b0;
        end
      end
      CCPSG_CG_RISE: begin
        if (r.arm && rise) begin
          n.cdis = 1'b0;
          n.arm  = 1'b0;
        end
      end
      default: begin
        // reserved code leaves the gate untouched
      end
    endcase

    capv      = r.sync2[15:8];
    capin     = capv[r.osc[2:0]];
    n.cap_d   = capin;
    n.cap_evt = capin & ~r.cap_d & ~r.cdis;

    // one dead-time period is one mclk_i cycle
    n.pwm_d = pwm_i;
    if (pwm_i != r.pwm_d) begin
      n.dt_cnt = r.dtc[5:0];
    end else if (r.dt_cnt != 6'h00) begin
      n.dt_cnt = r.dt_cnt - 6'h01;
    end
    live   = (n.dt_cnt == 6'h00);
    wave_a = pwm_i & live;
    wave_b = ~pwm_i & live;

    for (int i = 0; i < 6; i++) begin
      wave = (i % 2 == 0) ? wave_a : wave_b;
      ss   = (i % 2 == 0) ? ss_ace_i : ss_bdf_i;
      if (!n.pen_act[i]) begin
        n.pins.data[i] = 1'b0;
        n.pins.oe_n[i] = 1'b1;
      end else if (n.shd) begin
        if (ss == CCPSG_SS_ACTIVE) begin
          n.pins.data[i] = 1'b1;
          n.pins.oe_n[i] = 1'b0;
        end else if (ss == CCPSG_SS_INACTIVE) begin
          n.pins.data[i] = 1'b0;
          n.pins.oe_n[i] = 1'b0;
        end else begin
          n.pins.data[i] = 1'b0;
          n.pins.oe_n[i] = 1'b1;
        end
      end else begin
        n.pins.data[i] = wave;
        n.pins.oe_n[i] = 1'b0;
      end
    end

    case (ccpsg_aux_t'(r.osc[4:3]))
      CCPSG_AUX_EVT:  n.aux = ~timer_mode_i & (n.cap_evt | cmp_evt_i);
      CCPSG_AUX_MODE: n.aux = mode_sig_i;
      CCPSG_AUX_ROLL: n.aux = tb_reset_i;
      default:        n.aux = 1'b0;
    endcase

    ev                = 3'h0;
    ev[CCPSG_EV_SHD]  = n.shd & ~r.shd;
    ev[CCPSG_EV_CAP]  = n.cap_evt;
    ev[CCPSG_EV_CDIS] = n.cdis & ~r.cdis;
    if (wr_ist) begin
      n.ist = r.ist & ~wdata_i[2:0];
    end
    n.ist = n.ist | ev;
    n.irq = |(n.ist & n.imsk);

    stat                 = 16'h0000;
    stat[CCPSG_SHD_BIT]  = r.shd;
    stat[CCPSG_CDIS_BIT] = r.cdis; // arm bit reads zero
    n.rdata = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        CCPSG_SGC_OFS:  n.rdata = r.sgc;
        CCPSG_OSC_OFS:  n.rdata = r.osc;
        CCPSG_DTC_OFS:  n.rdata = r.dtc;
        CCPSG_STAT_OFS: n.rdata = stat;
        CCPSG_IST_OFS:  n.rdata = {13'h0, r.ist};
        CCPSG_IMSK_OFS: n.rdata = {13'h0, r.imsk};
        default:        n.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      r           <= '0;
      r.sgc       <= CCPSG_SGC_RST;
      r.osc       <= CCPSG_OSC_RST;
      r.dtc       <= CCPSG_DTC_RST;
      r.ist       <= CCPSG_IRQ_RST;
      r.imsk      <= CCPSG_IRQ_RST;
      r.pins.oe_n <= 6'h3f;
    end else begin
      r <= n;
    end
  end

  assign rdata_o    = r.rdata;
  assign pin_out_o  = r.pins.data;
  assign pin_oe_n_o = r.pins.oe_n;
  assign cap_evt_o  = r.cap_evt;
  assign aux_o      = r.aux;
  assign irq_o      = r.irq;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  a_restart_clear: assert property (
    r.shd && r.sgc[CCPSG_RSEN_BIT] && !req && period_start_i |=> !r.shd)
    else $error("shutdown did not self-clear at period start");
  a_no_self_clear: assert property (
    r.shd && !r.sgc[CCPSG_RSEN_BIT] && !wr_stat |=> r.shd)
    else $error("shutdown cleared without software");
  a_gated_wait: assert property (
    r.sgc[CCPSG_GMODE_BIT] && !tb_reset_i && !r.shd |=> !r.shd)
    else $error("gated shutdown entered before rollover");
  a_sw_force: assert property (
    r.sgc[CCPSG_SOFTWARE_SHUTDOWN_GATE_BIT] && !r.sgc[CCPSG_GMODE_BIT] |=> r.shd)
    else $error("software shutdown not taken");
  a_src_request: assert property (
    (|(r.sync2[7:0] & r.sgc[7:0])) && !r.sgc[CCPSG_GMODE_BIT] |=> r.shd)
    else $error("enabled source did not shut down");
  a_pen_sync: assert property (
    r.osc[CCPSG_PSYNC_BIT] && !tb_reset_i && !wr_osc |=> $stable(r.pen_act))
    else $error("pin enables changed off rollover");
  a_pin_release: assert property (
    !r.pen_act[0] |-> r.pins.oe_n[0])
    else $error("released pin still driven");
  a_single_out: assert property (
    !MULTI_OUTPUT |-> r.osc[13:9] == 5'h00)
    else $error("upper enables present on single variant");
  a_oneshot_fall: assert property (
    gmode == CCPSG_CG_FALL && r.arm && fall |=> r.cdis && !r.arm)
    else $error("armed fall did not disable capture");
  a_oneshot_rise: assert property (
    gmode == CCPSG_CG_RISE && r.arm && rise |=> !r.cdis && !r.arm)
    else $error("armed rise did not enable capture");
  a_level_gate: assert property (
    resetn_i && gmode == CCPSG_CG_LEVEL |=> r.cdis != $past(req))
    else $error("level gate mismatch");
  a_aux_roll: assert property (
    r.osc[4:3] == 2'b01 |=> r.aux == $past(tb_reset_i))
    else $error("aux rollover mismatch");
  a_cap_pin: assert property (
    r.osc[2:0] == 3'h0 && r.sync2[8] && !r.cap_d && !r.cdis |=> r.cap_evt)
    else $error("capture pin edge lost");
  a_dead_load: assert property (
    pwm_i != r.pwm_d |=> r.dt_cnt == $past(r.dtc[5:0]))
    else $error("dead-time count not loaded");
  a_shd_state: assert property (
    r.shd && r.pen_act[0] && $past(ss_ace_i) == CCPSG_SS_INACTIVE
    |-> !r.pins.data[0] && !r.pins.oe_n[0])
    else $error("shutdown pin not inactive");
  a_cdis_block: assert property (
    r.cdis |=> !r.cap_evt)
    else $error("capture while disabled");

  c_shutdown: cover property (!r.shd ##1 r.shd ##[1:20] !r.shd);
  c_oneshot:  cover property (r.arm && fall ##1 r.cdis);
  c_deadtime: cover property (r.dt_cnt == 6'h03 ##3 r.dt_cnt == 6'h00);
  c_irq:      cover property (!r.irq ##1 r.irq);

endmodule

// [rtl/ccpsg_pkg.sv]
package ccpsg_pkg;

  // register offsets on the plain port
  localparam logic [11:0] CCPSG_SGC_OFS  = 12'h294;
  localparam logic [11:0] CCPSG_OSC_OFS  = 12'h296;
  localparam logic [11:0] CCPSG_DTC_OFS  = 12'h298;
  localparam logic [11:0] CCPSG_STAT_OFS = 12'h29c;
  localparam logic [11:0] CCPSG_IST_OFS  = 12'h2a0;
  localparam logic [11:0] CCPSG_IMSK_OFS = 12'h2a2;

  // reset values
  localparam logic [15:0] CCPSG_SGC_RST  = 16'h0000;
  localparam logic [15:0] CCPSG_OSC_RST  = 16'h0000;
  localparam logic [15:0] CCPSG_DTC_RST  = 16'h0000;
  localparam logic [2:0]  CCPSG_IRQ_RST  = 3'h0;

  // implemented bits
  localparam logic [15:0] CCPSG_SGC_MASK   = 16'hd0ff;
  localparam logic [15:0] CCPSG_OSC_MASK   = 16'hbfdf;
  localparam logic [15:0] CCPSG_OSC_UPPER  = 16'h3e00;
  localparam logic [15:0] CCPSG_DTC_MASK   = 16'h003f;

  // field positions
  localparam int CCPSG_RSEN_BIT  = 15;
  localparam int CCPSG_GMODE_BIT = 14;
  localparam int CCPSG_SOFTWARE_SHUTDOWN_GATE_BIT  = 12;
  localparam int CCPSG_PSYNC_BIT = 15;
  localparam int CCPSG_SHD_BIT   = 4;
  localparam int CCPSG_CDIS_BIT  = 2;
  localparam int CCPSG_ARM_BIT   = 10;

  // interrupt status bits
  localparam int CCPSG_EV_SHD  = 0;
  localparam int CCPSG_EV_CAP  = 1;
  localparam int CCPSG_EV_CDIS = 2;

  typedef enum logic [1:0] {
    CCPSG_CG_LEVEL = 2'b00,
    CCPSG_CG_RISE  = 2'b01,
    CCPSG_CG_FALL  = 2'b10,
    CCPSG_CG_RSVD  = 2'b11
  } ccpsg_gmode_t;

  typedef enum logic [1:0] {
    CCPSG_AUX_OFF  = 2'b00,
    CCPSG_AUX_ROLL = 2'b01,
    CCPSG_AUX_MODE = 2'b10,
    CCPSG_AUX_EVT  = 2'b11
  } ccpsg_aux_t;

  localparam logic [1:0] CCPSG_SS_ACTIVE   = 2'b11;
  localparam logic [1:0] CCPSG_SS_INACTIVE = 2'b10;

  typedef struct packed {
    logic [5:0] data;
    logic [5:0] oe_n;
  } ccpsg_pins_t;

  typedef struct packed {
    logic [15:0] sgc;
    logic [15:0] osc;
    logic [15:0] dtc;
    logic [5:0]  pen_act;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic        req_d;
    logic        cap_d;
    logic        pwm_d;
    logic        shd;
    logic        cdis;
    logic        arm;
    logic [5:0]  dt_cnt;
    logic [2:0]  ist;
    logic [2:0]  imsk;
    logic        irq;
    ccpsg_pins_t pins;
    logic        aux;
    logic        cap_evt;
    logic [15:0] rdata;
  } ccpsg_state_t;

endpackage
